// file: design/sde_pkg.sv
// Shared constants and helpers for the DDR burst-of-two ECC SRAM link.
package sde_pkg;
    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int DQ_W = 18;
    localparam int LANE_W = 9;
    localparam int LANES = 2;
    localparam int WORD_W = 18;
    localparam int PAR_W = 5;
    localparam int CODE_W = 23;
    localparam int ADDR_W = 21;
    // ----------------------------------------
    // Timing counts, in link clock cycles
    // ----------------------------------------
    localparam int RD_LAT = 2;
    localparam int IMP_SETUP_CYC = 163840;
    localparam int DLL_LOCK_CYC = 65536;
    localparam int RD_WR_GAP = 2;
    // Controller clock phases within one link clock period.
    localparam logic [1:0] PH_KRISE = 2'h3;
    localparam logic [1:0] PH_BEAT2 = 2'h0;
    localparam logic [1:0] PH_KFALL = 2'h1;
    localparam logic [1:0] PH_CMD = 2'h2;

    // Pulls the data bits out of a codeword, parity positions skipped.
    function automatic logic [WORD_W-1:0] code_data(input logic [CODE_W-1:0] c);
        logic [WORD_W-1:0] d;
        int j;
        d = '0;
        j = 0;
        for (int p = 1; p <= CODE_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                d[j] = c[p-1];
                j++;
            end
        end
        return d;
    endfunction
endpackage

// file: design/sde_link_if.sv
// Pin-level link between the memory controller and the SRAM device.
`timescale 1ns/100ps
interface sde_link_if #(
    parameter int ADDR_W = sde_pkg::ADDR_W
);
    logic k;
    logic k_n;
    logic [ADDR_W-1:0] sync_address;
    logic load_n;
    logic read_not_write;
    logic [sde_pkg::LANES-1:0] byte_lane_enable_n;
    logic dll_disable_n;
    logic echo_strobe;
    logic read_valid_flag;
    logic [sde_pkg::DQ_W-1:0] dq_ctrl_o;
    logic dq_ctrl_oe;
    logic [sde_pkg::DQ_W-1:0] dq_dev_o;
    logic dq_dev_oe;
    wire [sde_pkg::DQ_W-1:0] dq;

    // Shared data bus, resolved from the two enables.
    // An idle bus reads as all ones, so stale data from the last transfer cannot pass for fresh data.
    assign dq = dq_dev_oe ? dq_dev_o : (dq_ctrl_oe ? dq_ctrl_o : '1);

    modport device (
        input k, k_n, sync_address, load_n, read_not_write,
        input byte_lane_enable_n, dll_disable_n, dq,
        output dq_dev_o, dq_dev_oe, echo_strobe, read_valid_flag
    );
    modport ctrl (
        output k, k_n, sync_address, load_n, read_not_write,
        output byte_lane_enable_n, dll_disable_n, dq_ctrl_o, dq_ctrl_oe,
        input dq, echo_strobe, read_valid_flag
    );
endinterface

// file: design/sde_hamming.sv
// Single-error-correcting Hamming encoder and decoder for one 18-bit word.
`timescale 1ns/100ps
module sde_hamming (
    input wire logic [sde_pkg::WORD_W-1:0] wr_data, // Word to protect.
    output logic [sde_pkg::CODE_W-1:0] wr_code, // Codeword to store.
    input wire logic [sde_pkg::CODE_W-1:0] rd_code, // Codeword as stored.
    input wire logic correct_en, // High lets a single flip be repaired.
    output logic [sde_pkg::WORD_W-1:0] rd_data // Word handed back.
);
    import sde_pkg::*;

    // Parity of every position whose index has the given bit set.
    function automatic logic [PAR_W-1:0] syndrome(input logic [CODE_W-1:0] c);
        logic [PAR_W-1:0] s;
        s = '0;
        for (int i = 0; i < PAR_W; i++) begin
            for (int p = 1; p <= CODE_W; p++) begin
                if (((p >> i) & 1) == 1) begin
                    s[i] = s[i] ^ c[p-1];
                end
            end
        end
        return s;
    endfunction

    always_comb begin
        logic [CODE_W-1:0] c;
        logic [PAR_W-1:0] s;
        int j;
        c = '0;
        s = '0;
        j = 0;
        for (int p = 1; p <= CODE_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                c[p-1] = wr_data[j];
                j++;
            end
        end
        s = syndrome(c);
        for (int i = 0; i < PAR_W; i++) begin
            c[(1 << i) - 1] = s[i];
        end
        wr_code = c;
    end

    // no multi-bit handling
    // A zero or out-of-range syndrome leaves the word alone and nothing is flagged.
    always_comb begin
        logic [CODE_W-1:0] f;
        logic [PAR_W-1:0] s;
        f = rd_code;
        s = syndrome(rd_code);
        if (correct_en && s != '0 && s <= PAR_W'(CODE_W)) begin
            f[s - 1'b1] = ~f[s - 1'b1];
        end
        rd_data = code_data(f);
    end
endmodule

// file: design/sde_sram.sv
// Device end: burst-of-two common-I/O DDR SRAM with per-lane ECC.
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/100ps
module sde_sram #(
    parameter int ADDR_W = sde_pkg::ADDR_W // Loaded address width.
) (
    sde_link_if.device LINK, // Memory pins.
    input wire logic RST, // Asynchronous reset, active high.
    input wire logic [sde_pkg::CODE_W-1:0] ERR_INJECT, // Flips for lane 0 writes.
    output logic ECC_ON, // High while correction is enabled.
    output logic DLL_ON // High while the DLL is enabled.
);
    import sde_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;
    localparam int LW = LANES * CODE_W;

    // ----------------------------------------
    // Storage and pipeline state
    // ----------------------------------------
    // One line per address holds both beats of every lane.
    logic [LW-1:0] mem [DEPTH];
    logic rd_pend;
    logic wr_pend;
    logic rd_go;
    logic wr_go;
    logic [ADDR_W-1:0] cmd_addr;
    logic [ADDR_W-1:0] stage_addr;
    logic [DQ_W-1:0] beat1;
    logic [LANES-1:0] be1_n;
    logic [LANES*WORD_W-1:0] word_q;
    logic drv_k;
    logic drv_kn;
    logic tog_k;
    logic tog_kn;
    logic dll_s1;
    logic dll_s2;
    logic [CODE_W-1:0] inj_s1;
    logic [CODE_W-1:0] inj_s2;
    logic [LW-1:0] rd_line;
    logic [LW-1:0] new_line;
    logic [LANES*WORD_W-1:0] rd_word;
    logic [LANES-1:0] half;
    logic [DQ_W-1:0] q_b1;
    logic [DQ_W-1:0] q_b2;
    logic first_half;

    // Read and merge both work on the line at the staged address.
    assign rd_line = mem[stage_addr];

    // ----------------------------------------
    // Primary-edge command pipeline
    // ----------------------------------------
    // primary edge sampling
    // load high means idle
    // A deselect simply enters the same pipeline as an empty slot,
    // so it can never cut short a read already on its way.
    always_ff @(posedge LINK.k or posedge RST) begin
        if (RST) begin
            rd_pend <= 1'b0;
            wr_pend <= 1'b0;
            rd_go <= 1'b0;
            wr_go <= 1'b0;
            cmd_addr <= '0;
            stage_addr <= '0;
        end else begin
            rd_pend <= !LINK.load_n && LINK.read_not_write;
            wr_pend <= !LINK.load_n && !LINK.read_not_write;
            cmd_addr <= LINK.sync_address;
            rd_go <= rd_pend;
            wr_go <= wr_pend;
            stage_addr <= cmd_addr;
        end
    end

    // enables with data
    // Captured every edge; only used when a write sits in stage.
    always_ff @(posedge LINK.k or posedge RST) begin
        if (RST) begin
            beat1 <= '0;
            be1_n <= '1;
        end else begin
            beat1 <= LINK.dq;
            be1_n <= LINK.byte_lane_enable_n;
        end
    end

    always_ff @(posedge LINK.k or posedge RST) begin
        if (RST) begin
            word_q <= '0;
            drv_k <= 1'b0;
            tog_k <= 1'b0;
        end else begin
            word_q <= rd_word;
            drv_k <= rd_go;
            tog_k <= ~tog_k;
        end
    end

    // DLL disable level
    // The pin comes from another clock, so it is synchronised first.
    always_ff @(posedge LINK.k or posedge RST) begin
        if (RST) begin
            dll_s1 <= 1'b0;
            dll_s2 <= 1'b0;
            DLL_ON <= 1'b0;
        end else begin
            dll_s1 <= LINK.dll_disable_n;
            dll_s2 <= dll_s1;
            DLL_ON <= dll_s2;
        end
    end

    // ----------------------------------------
    // Per-lane merge and ECC
    // ----------------------------------------
    genvar l;
    generate
        for (l = 0; l < LANES; l++) begin : g_lane
            logic [WORD_W-1:0] old_w;
            logic [WORD_W-1:0] mrg;
            logic [CODE_W-1:0] enc;
            logic [CODE_W-1:0] flips;
            logic be2_n;

            assign old_w = code_data(rd_line[l*CODE_W +: CODE_W]);
            assign be2_n = LINK.byte_lane_enable_n[l];
            // masked byte kept
            // Low half of the lane word is beat 1, high half is beat 2.
            assign mrg[LANE_W-1:0] = be1_n[l] ? old_w[LANE_W-1:0] : beat1[l*LANE_W +: LANE_W];
            assign mrg[WORD_W-1:LANE_W] = be2_n ? old_w[WORD_W-1:LANE_W] : LINK.dq[l*LANE_W +: LANE_W];
            assign half[l] = be1_n[l] ^ be2_n;
            assign flips = (l == 0) ? inj_s2 : '0;
            // An aborted lane is not rewritten, so even its parity stays as it was.
            assign new_line[l*CODE_W +: CODE_W] = (be1_n[l] && be2_n) ? rd_line[l*CODE_W +: CODE_W] : (enc ^ flips);
            // Read beats leave the lane word in beat order.
            assign q_b1[l*LANE_W +: LANE_W] = word_q[l*WORD_W +: LANE_W];
            assign q_b2[l*LANE_W +: LANE_W] = word_q[l*WORD_W+LANE_W +: LANE_W];

            sde_hamming u_ham (
                .wr_data(mrg),
                .wr_code(enc),
                .rd_code(rd_line[l*CODE_W +: CODE_W]),
                .correct_en(ECC_ON),
                .rd_data(rd_word[l*WORD_W +: WORD_W])
            );
        end
    endgenerate

    // ----------------------------------------
    // Inverted-edge write and output phase
    // ----------------------------------------
    // one line per address
    // second beat completes write
    // The array is written once, at the second beat, so a read staged
    // on the next primary edge already sees the new contents.
    always_ff @(posedge LINK.k_n) begin
        if (wr_go) begin
            mem[stage_addr] <= new_line;
        end
    end

    // sticky ECC disable
    // Only reset clears it; the code spans the whole lane word.
    always_ff @(posedge LINK.k_n or posedge RST) begin
        if (RST) begin
            ECC_ON <= 1'b1;
        end else if (wr_go && half != '0) begin
            ECC_ON <= 1'b0;
        end
    end

    // Second read beat and the phase marker for the output mux.
    always_ff @(posedge LINK.k_n or posedge RST) begin
        if (RST) begin
            drv_kn <= 1'b0;
            tog_kn <= 1'b0;
            inj_s1 <= '0;
            inj_s2 <= '0;
        end else begin
            drv_kn <= drv_k;
            tog_kn <= tog_k;
            inj_s1 <= ERR_INJECT;
            inj_s2 <= inj_s1;
        end
    end

    // ----------------------------------------
    // DDR output
    // ----------------------------------------
    // The toggles differ between a primary rise and the next inverted
    // rise, which picks the beat without using a clock as data.
    assign first_half = tog_k ^ tog_kn;

    always_comb begin
        LINK.dq_dev_o = first_half ? q_b1 : q_b2;
        LINK.dq_dev_oe = first_half ? drv_k : drv_kn;
        LINK.read_valid_flag = first_half ? drv_k : drv_kn;
        LINK.echo_strobe = first_half;
    end
endmodule

// file: design/sde_ctrl.sv
// Controller end: makes the link clocks, waits out power-up, issues bursts.
`timescale 1ns/100ps
module sde_ctrl #(
    parameter int ADDR_W = sde_pkg::ADDR_W, // Loaded address width.
    parameter int IMP_CYC = sde_pkg::IMP_SETUP_CYC, // Impedance setup wait.
    parameter int DLL_CYC = sde_pkg::DLL_LOCK_CYC // DLL lock wait.
) (
    input wire logic CLOCK, // System clock.
    input wire logic RST, // Asynchronous reset, active high.
    sde_link_if.ctrl LINK, // Memory pins.
    input wire logic REQ, // Request, held until taken.
    input wire logic REQ_WRITE, // High for write, low for read.
    input wire logic [ADDR_W-1:0] REQ_ADDR, // Burst address.
    input wire logic [2*sde_pkg::DQ_W-1:0] WDATA, // Beat 2 high, beat 1 low.
    input wire logic [2*sde_pkg::LANES-1:0] WBE_N, // Lane enables, beat 2 high.
    input wire logic DLL_OFF, // High asks for the DLL off.
    output logic READY, // One-cycle window in which REQ is taken.
    output logic INIT_DONE, // Power-up wait finished.
    output logic [2*sde_pkg::DQ_W-1:0] RDATA, // Read burst, beat 2 high.
    output logic RVALID // One-cycle pulse with RDATA.
);
    import sde_pkg::*;

    localparam int INIT_W = $clog2(IMP_CYC + DLL_CYC + 1);

    logic [1:0] ph;
    logic [INIT_W-1:0] init_cnt;
    logic [1:0] blk;
    logic accept;
    logic wr_pend;
    logic [2*DQ_W-1:0] pend_d;
    logic [2*LANES-1:0] pend_be;
    logic [DQ_W-1:0] cur_d2;
    logic [LANES-1:0] cur_be2;
    logic [DQ_W-1:0] dq_s1;
    logic [DQ_W-1:0] dq_s2;
    logic vld_s1;
    logic vld_s2;
    logic [DQ_W-1:0] rlo;

    assign accept = READY && REQ;

    // ----------------------------------------
    // Link clock divider
    // ----------------------------------------
    // Four system cycles per link cycle keep every command and write-data pin change one whole
    // phase away from the edge that samples it.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ph <= 2'h0;
            LINK.k <= 1'b0;
            LINK.k_n <= 1'b0;
        end else begin
            ph <= ph + 2'h1;
            if (ph == PH_KRISE) begin
                LINK.k <= 1'b1;
                LINK.k_n <= 1'b0;
            end else if (ph == PH_KFALL) begin
                LINK.k <= 1'b0;
                LINK.k_n <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            init_cnt <= '0;
            INIT_DONE <= 1'b0;
        end else if (ph == PH_CMD && !INIT_DONE) begin
            init_cnt <= init_cnt + 1'b1;
            INIT_DONE <= (init_cnt == INIT_W'(IMP_CYC + DLL_CYC - 1));
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            LINK.dll_disable_n <= 1'b1;
        end else begin
            LINK.dll_disable_n <= !DLL_OFF;
        end
    end

    // ----------------------------------------
    // Command issue
    // ----------------------------------------
    // one slot per cycle
    // After a read the slots that would collide on the bus are skipped.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            READY <= 1'b0;
            blk <= 2'h0;
            LINK.load_n <= 1'b1;
            LINK.read_not_write <= 1'b1;
            LINK.sync_address <= '0;
        end else begin
            READY <= INIT_DONE && blk == 2'h0 && ph == PH_KFALL;
            if (ph == PH_CMD) begin
                LINK.load_n <= !accept;
                LINK.read_not_write <= !(accept && REQ_WRITE);
                LINK.sync_address <= REQ_ADDR;
                if (accept && !REQ_WRITE) begin
                    blk <= 2'(RD_WR_GAP);
                end else if (blk != 2'h0) begin
                    blk <= blk - 2'h1;
                end
            end
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            wr_pend <= 1'b0;
            pend_d <= '0;
            pend_be <= '1;
            cur_d2 <= '0;
            cur_be2 <= '1;
            LINK.dq_ctrl_o <= '0;
            LINK.dq_ctrl_oe <= 1'b0;
            LINK.byte_lane_enable_n <= '1;
        end else if (ph == PH_CMD) begin
            wr_pend <= accept && REQ_WRITE;
            pend_d <= WDATA;
            pend_be <= WBE_N;
            cur_d2 <= pend_d[2*DQ_W-1:DQ_W];
            cur_be2 <= pend_be[2*LANES-1:LANES];
            LINK.dq_ctrl_o <= pend_d[DQ_W-1:0];
            LINK.dq_ctrl_oe <= wr_pend;
            LINK.byte_lane_enable_n <= wr_pend ? pend_be[LANES-1:0] : '1;
        end else if (ph == PH_BEAT2 && LINK.dq_ctrl_oe) begin
            LINK.dq_ctrl_o <= cur_d2;
            LINK.byte_lane_enable_n <= cur_be2;
        end
    end

    // ----------------------------------------
    // Read capture
    // ----------------------------------------
    // two beats gathered
    // Bus and valid flag cross from the link side through two flops.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            dq_s1 <= '0;
            dq_s2 <= '0;
            vld_s1 <= 1'b0;
            vld_s2 <= 1'b0;
            rlo <= '0;
            RDATA <= '0;
            RVALID <= 1'b0;
        end else begin
            dq_s1 <= LINK.dq;
            dq_s2 <= dq_s1;
            vld_s1 <= LINK.read_valid_flag;
            vld_s2 <= vld_s1;
            RVALID <= 1'b0;
            if (ph == PH_CMD && vld_s2) begin
                rlo <= dq_s2;
            end
            if (ph == PH_BEAT2 && vld_s2) begin
                RDATA <= {dq_s2, rlo};
                RVALID <= 1'b1;
            end
        end
    end
endmodule

// file: sim/sde_sva.sv
// Link-side assertions for the burst-of-two SRAM link.
`timescale 1ns/100ps
module sde_sva (
    input wire logic k, // Primary link clock.
    input wire logic RST, // Asynchronous reset, active high.
    input wire logic load_n, // Active low load.
    input wire logic read_not_write, // High selects read.
    input wire logic dq_ctrl_oe, // Controller drives the bus.
    input wire logic dq_dev_oe, // Device drives the bus.
    input wire logic echo_strobe, // Echo of the link clock.
    input wire logic read_valid_flag // Read data valid.
);
    logic rd_cmd;
    logic wr_cmd;

    // Commands as decoded at a primary rise.
    assign rd_cmd = !load_n && read_not_write;
    assign wr_cmd = !load_n && !read_not_write;

    // ----------------------------------------
    // Link timing
    // ----------------------------------------
    default clocking cb @(posedge k);
    endclocking
    default disable iff (RST);

    a_rd_start: assert property (rd_cmd |-> ##3 read_valid_flag) else $error("read burst missing");
    a_rd_stop: assert property (!rd_cmd |-> ##3 !read_valid_flag) else $error("bus not released");
    a_two_beats: assert property (rd_cmd ##1 !rd_cmd |-> ##3 !dq_dev_oe) else $error("burst too long");
    a_flag_oe: assert property (read_valid_flag |-> (dq_dev_oe && $past(rd_cmd, 3)))
        else $error("valid without read");
    a_wr_drive: assert property (wr_cmd |-> ##1 (dq_ctrl_oe && !dq_dev_oe)) else $error("write data late");
    a_wr_only: assert property (dq_ctrl_oe |-> $past(wr_cmd)) else $error("drive without write");
    a_no_clash: assert property (!(dq_ctrl_oe && dq_dev_oe)) else $error("bus contention");
    a_echo_low: assert property (!echo_strobe) else $error("echo high at rise");
    a_echo_high: assert property (@(negedge k) disable iff (RST) echo_strobe) else $error("echo low mid");
endmodule

// file: sim/tb_ddr_cio_burst2_sram_ecc.sv
// Self-checking bench joining the controller and SRAM ends across the link.
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module tb_ddr_cio_burst2_sram_ecc;
    import sde_pkg::*;
    localparam logic [35:0] D1 = 36'h123456789;
    localparam logic [35:0] D2 = 36'hABCDE0123;
    localparam logic [35:0] D3 = 36'h5A5A5A5A5;
    localparam logic [35:0] D4 = 36'h0F0F0F0F1;
    localparam logic [35:0] D5 = 36'hFEDCBA987;
    localparam logic [35:0] M0 = 36'h007FC01FF; // Lane 0 bits of both beats.
    logic CLOCK = 1'h0;
    logic RST = 1'h0;
    logic REQ = 1'h0;
    logic REQ_WRITE = 1'h0;
    logic [5:0] REQ_ADDR = 6'h00;
    logic [35:0] WDATA = 36'h000000000;
    logic [3:0] WBE_N = 4'hF;
    logic DLL_OFF = 1'h0;
    logic [CODE_W-1:0] ERR_INJECT = 23'h000000;
    logic READY, INIT_DONE, RVALID, ECC_ON, DLL_ON;
    logic [35:0] RDATA;
    logic [35:0] cap_beat = 36'h000000000;
    logic wr_pend = 1'h0;
    logic beat2_due = 1'h0;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;

    // ----------------------------------------
    // Ends, link and checker
    // ----------------------------------------
    sde_link_if #(.ADDR_W(6)) u_sde_link_if ();
    sde_ctrl #(.ADDR_W(6), .IMP_CYC(8), .DLL_CYC(4)) u_sde_ctrl (.CLOCK(CLOCK), .RST(RST),
        .LINK(u_sde_link_if.ctrl), .REQ(REQ), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR),
        .WDATA(WDATA), .WBE_N(WBE_N), .DLL_OFF(DLL_OFF), .READY(READY), .INIT_DONE(INIT_DONE),
        .RDATA(RDATA), .RVALID(RVALID));
    sde_sram #(.ADDR_W(6)) u_sde_sram (.LINK(u_sde_link_if.device), .RST(RST),
        .ERR_INJECT(ERR_INJECT), .ECC_ON(ECC_ON), .DLL_ON(DLL_ON));
    sde_sva u_sde_sva (.k(u_sde_link_if.k), .RST(RST), .load_n(u_sde_link_if.load_n),
        .read_not_write(u_sde_link_if.read_not_write), .dq_ctrl_oe(u_sde_link_if.dq_ctrl_oe),
        .dq_dev_oe(u_sde_link_if.dq_dev_oe), .echo_strobe(u_sde_link_if.echo_strobe),
        .read_valid_flag(u_sde_link_if.read_valid_flag));

    // System clock, 20 ns period.
    always #10 CLOCK = ~CLOCK;

    // Catch write beat 1 on the primary rise after a write command.
    always @(posedge u_sde_link_if.k) begin
        if (wr_pend) begin
            cap_beat[17:0] <= u_sde_link_if.dq;
        end
        beat2_due <= wr_pend;
        wr_pend <= !u_sde_link_if.load_n && !u_sde_link_if.read_not_write;
    end

    // Beat 2 follows on the inverted rise.
    always @(posedge u_sde_link_if.k_n) begin
        if (beat2_due) begin
            cap_beat[35:18] <= u_sde_link_if.dq;
        end
    end

    // A hang counts as a mismatch and ends the run.
    always @(posedge CLOCK) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fail_count++;
            close_out();
        end
    end

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic close_out;
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Holds the request until the one-cycle READY window takes it.
    task automatic req(input logic w, input logic [5:0] a, input logic [35:0] d, input logic [3:0] be);
        @(negedge CLOCK);
        REQ = 1'h1;
        REQ_WRITE = w;
        REQ_ADDR = a;
        WDATA = d;
        WBE_N = be;
        while (READY !== 1'h1) @(negedge CLOCK);
        @(negedge CLOCK);
        REQ = 1'h0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [35:0] exp);
        req(1'h0, a, 36'h000000000, 4'hF);
        while (RVALID !== 1'h1) @(negedge CLOCK);
        `CHK(RDATA, exp)
    endtask

    // Main sequence; waits are bounded by the cycle ceiling.
    initial begin
        // A real rising edge on reset is needed: the link end only sees k, which is idle in reset.
        @(negedge CLOCK);
        RST = 1'h1;
        repeat (3) @(negedge CLOCK);
        RST = 1'h0;
        // Twelve link cycles of wait are four system cycles each, so nothing is ready yet.
        repeat (44) @(negedge CLOCK);
        `CHK(INIT_DONE, 1'h0)
        while (INIT_DONE !== 1'h1) @(negedge CLOCK);
        `CHK(DLL_ON, 1'h1)
        `CHK(ECC_ON, 1'h1)
        req(1'h1, 6'h01, D1, 4'h0);
        req(1'h1, 6'h02, D2, 4'h0);
        repeat (12) @(negedge CLOCK);
        `CHK(cap_beat, D2)
        rd(6'h01, D1);
        rd(6'h02, D2);
        // Lane 1 masked on both beats must keep its old byte.
        req(1'h1, 6'h01, D3, 4'hA);
        rd(6'h01, (D3 & M0) | (D1 & ~M0));
        // One flipped stored bit is repaired while correction is on.
        ERR_INJECT = 23'h000004;
        repeat (16) @(negedge CLOCK);
        req(1'h1, 6'h03, D4, 4'h0);
        repeat (16) @(negedge CLOCK);
        ERR_INJECT = 23'h000000;
        repeat (16) @(negedge CLOCK);
        rd(6'h03, D4);
        // Lane 0 enabled on beat 1 only: a half write.
        req(1'h1, 6'h02, D5, 4'hE);
        rd(6'h02, {D2[35:9], D5[8:0]});
        `CHK(ECC_ON, 1'h0)
        DLL_OFF = 1'h1;
        repeat (24) @(negedge CLOCK);
        `CHK(u_sde_link_if.dll_disable_n, 1'h0)
        `CHK(DLL_ON, 1'h0)
        // A second reset restores correction; the array keeps its data.
        RST = 1'h1;
        DLL_OFF = 1'h0;
        repeat (3) @(negedge CLOCK);
        RST = 1'h0;
        `CHK(ECC_ON, 1'h1)
        while (INIT_DONE !== 1'h1) @(negedge CLOCK);
        rd(6'h01, (D3 & M0) | (D1 & ~M0));
        close_out();
    end
endmodule
